//--- verilog/i2cme_engine.sv
// i2cme_engine: i2c master byte engine with its command fifo.
// assumes open-drain pads with external pull-ups; link_clk_in runs free.
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// command fifo
module i2cme_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clock_in,       // system clock
  input  wire logic         reset_n_in,     // async reset, active low
  input  wire logic         in_valid_in,    // write side valid
  input  wire logic [W-1:0] in_data_in,     // write side word
  output logic              in_ready_out,   // write side ready
  output logic              out_valid_out,  // read side valid
  output logic [W-1:0]      out_data_out,   // read side word
  input  wire logic         out_ready_in    // read side ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } i2cme_fifo_st_t;

  i2cme_fifo_st_t f_reg;
  i2cme_fifo_st_t f_next;
  logic           push;
  logic           pop;

  function automatic logic [AW-1:0] i2cme_wrap(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) return '0;
    return p + AW'(1);
  endfunction : i2cme_wrap

  assign push          = in_valid_in & f_reg.rdy;
  assign pop           = out_ready_in & (f_reg.cnt != '0);
  assign in_ready_out  = f_reg.rdy;
  assign out_valid_out = (f_reg.cnt != '0);
  assign out_data_out  = f_reg.mem[f_reg.rp];

  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.mem[f_reg.wp] = in_data_in;
      f_next.wp            = i2cme_wrap(f_reg.wp);
    end
    if (pop) f_next.rp = i2cme_wrap(f_reg.rp);
    if (push && !pop) f_next.cnt = f_reg.cnt + (AW+1)'(1);
    else if (pop && !push) f_next.cnt = f_reg.cnt - (AW+1)'(1);
    f_next.rdy = (f_next.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      f_reg     <= '0;
      f_reg.rdy <= 1'b1;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule : i2cme_fifo

////////////////////////////////////////////////////////////////////////////
// engine top
module i2cme_engine #(
  parameter int WR_WAIT_CYC = i2cme_pkg::WR_CYC,     // eeprom write time, system cycles
  parameter int QTR_CYC     = i2cme_pkg::QTR_CYC,    // quarter scl period, link cycles
  parameter int FIFO_DEPTH  = i2cme_pkg::FIFO_DEPTH  // queued operations
) (
  input  wire logic                   clock_in,      // system clock
  input  wire logic                   reset_n_in,    // async reset, active low
  input  wire logic                   link_clk_in,   // bit timing clock
  input  wire logic                   pins_cfg_in,   // line pins configured
  input  wire logic                   cmd_valid_in,  // operation offered
  input  wire i2cme_pkg::i2cme_cmd_t  cmd_in,        // operation
  output logic                        cmd_ready_out, // queue has room
  output logic                        rsp_valid_out, // answer pulse
  output i2cme_pkg::i2cme_rsp_t       rsp_out,       // answer
  output logic                        wr_wait_out,   // eeprom write time running
  input  wire logic                   scl_in,        // scl pad level
  output logic                        scl_out,       // scl pad drive level
  output logic                        scl_oe_out,    // scl pad pulled low
  input  wire logic                   sda_in,        // sda pad level
  output logic                        sda_out,       // sda pad drive level
  output logic                        sda_oe_out     // sda pad pulled low
);
  localparam int CW  = $bits(i2cme_pkg::i2cme_cmd_t);
  localparam int WCW = $clog2(WR_WAIT_CYC + 1);

  typedef enum logic [0:0] {S_IDLE, S_WAIT} i2cme_sst_t;
  typedef enum logic [1:0] {L_IDLE, L_START, L_STOP, L_BYTE} i2cme_lst_t;

  typedef struct packed {
    i2cme_sst_t            st;
    i2cme_pkg::i2cme_cmd_t cmd;
    logic                  req_tgl;
    logic [1:0]            ack_s;
    logic                  ack_seen;
    logic [WCW-1:0]        wcnt;
    logic [1:0]            nbyte;
    logic                  ee_wr;
    logic                  ee_data;
    logic                  rsp_valid;
    i2cme_pkg::i2cme_rsp_t rsp;
    logic                  wr_wait;
  } i2cme_sys_t;

  typedef struct packed {
    i2cme_lst_t            st;
    logic [1:0]            qtr;
    logic [7:0]            tmr;
    logic [3:0]            bit_n;
    logic [7:0]            sh;
    i2cme_pkg::i2cme_op_t  op;
    logic                  rx_nack;
    logic                  busy;
    logic                  scl_oe;
    logic                  sda_oe;
    logic                  scl_o;
    logic                  sda_o;
    logic [2:0]            sda_s;
    logic [2:0]            scl_s;
    logic                  sda_lvl;
    logic                  scl_lvl;
    logic [1:0]            req_s;
    logic                  req_seen;
    logic                  ack_tgl;
    logic [7:0]            r_data;
    logic                  r_nack;
    logic                  r_busy;
    logic                  r_idle;
  } i2cme_lnk_t;

  i2cme_sys_t            s_reg;
  i2cme_sys_t            s_next;
  i2cme_lnk_t            l_reg;
  i2cme_lnk_t            l_next;
  logic                  f_push;
  logic                  f_valid;
  logic [CW-1:0]         f_data;
  logic                  dispatch;
  logic                  ack_new;
  logic                  req_new;
  logic                  tick;

  // control byte decoding
  function automatic logic i2cme_is_ee(input logic [7:0] b);
    return b[7:i2cme_pkg::CTRL_TYPE_LSB] == i2cme_pkg::EE_TYPE;
  endfunction : i2cme_is_ee

  function automatic logic i2cme_is_ee_write(input logic [7:0] b);
    return i2cme_is_ee(b) && (b[i2cme_pkg::CTRL_DIR_BIT] == i2cme_pkg::DIR_WRITE);
  endfunction : i2cme_is_ee_write

  ////////////////////////////////////////////////////////////////////////////
  // queue: nothing enters before the pins are configured
  assign f_push = cmd_valid_in & pins_cfg_in;

  i2cme_fifo #(
    .W     (CW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (f_push),
    .in_data_in    (cmd_in),
    .in_ready_out  (cmd_ready_out),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (dispatch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system domain: dispatch, answer capture, eeprom write wait
  assign ack_new  = s_reg.ack_s[1] != s_reg.ack_seen;
  assign dispatch = (s_reg.st == S_IDLE) && f_valid && (s_reg.wcnt == '0);

  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.ack_s     = {s_reg.ack_s[0], l_reg.ack_tgl};
    if (s_reg.wcnt != '0) s_next.wcnt = s_reg.wcnt - WCW'(1);
    case (s_reg.st)
      S_IDLE: begin
        if (dispatch) begin
          s_next.cmd     = i2cme_pkg::i2cme_cmd_t'(f_data);
          s_next.req_tgl = ~s_reg.req_tgl;
          s_next.st      = S_WAIT;
        end
      end
      default: begin
        if (ack_new) begin
          s_next.ack_seen       = s_reg.ack_s[1];
          s_next.rsp_valid      = 1'b1;
          s_next.rsp.data       = l_reg.r_data;
          s_next.rsp.nack       = l_reg.r_nack;
          s_next.rsp.busy       = l_reg.r_busy;
          s_next.rsp.lines_high = l_reg.r_idle;
          s_next.st             = S_IDLE;
          // track the write sequence to know when the eeprom needs its time
          case (s_reg.cmd.op)
            i2cme_pkg::OP_START: begin
              s_next.nbyte   = 2'h0;
              s_next.ee_wr   = 1'b0;
              s_next.ee_data = 1'b0;
            end
            i2cme_pkg::OP_SEND: begin
              if (s_reg.nbyte == 2'h0) s_next.ee_wr = i2cme_is_ee_write(s_reg.cmd.data);
              if (s_reg.nbyte == i2cme_pkg::EE_DATA_IDX && s_reg.ee_wr) s_next.ee_data = 1'b1;
              if (s_reg.nbyte != i2cme_pkg::EE_DATA_IDX) s_next.nbyte = s_reg.nbyte + 2'h1;
            end
            i2cme_pkg::OP_STOP: begin
              if (s_reg.ee_data) s_next.wcnt = WCW'(WR_WAIT_CYC);
              s_next.ee_wr   = 1'b0;
              s_next.ee_data = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
    s_next.wr_wait = (s_next.wcnt != '0);
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign rsp_valid_out = s_reg.rsp_valid;
  assign rsp_out       = s_reg.rsp;
  assign wr_wait_out   = s_reg.wr_wait;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: bit timing, four quarters per scl period
  assign req_new = l_reg.req_s[1] != l_reg.req_seen;
  assign tick    = (l_reg.tmr == '0);

  always_comb begin
    logic done;
    done          = 1'b0;
    l_next        = l_reg;
    l_next.sda_s  = {l_reg.sda_s[1:0], sda_in};
    l_next.scl_s  = {l_reg.scl_s[1:0], scl_in};
    if (l_reg.sda_s[2] == l_reg.sda_s[1]) l_next.sda_lvl = l_reg.sda_s[2];
    if (l_reg.scl_s[2] == l_reg.scl_s[1]) l_next.scl_lvl = l_reg.scl_s[2];
    l_next.req_s  = {l_reg.req_s[0], s_reg.req_tgl};
    if (l_reg.st != L_IDLE) l_next.tmr = tick ? 8'(QTR_CYC - 1) : l_reg.tmr - 8'h1;
    case (l_reg.st)
      L_IDLE: begin
        if (req_new) begin
          l_next.req_seen = l_reg.req_s[1];
          l_next.op       = s_reg.cmd.op;
          l_next.sh       = s_reg.cmd.data;
          l_next.rx_nack  = s_reg.cmd.nack;
          l_next.r_data   = s_reg.cmd.data;
          l_next.r_nack   = 1'b0;
          l_next.qtr      = 2'h0;
          l_next.bit_n    = 4'h0;
          l_next.tmr      = 8'(QTR_CYC - 1);
          case (s_reg.cmd.op)
            i2cme_pkg::OP_START: l_next.st = L_START;
            i2cme_pkg::OP_STOP: begin
              if (l_reg.busy) l_next.st = L_STOP;
              else done = 1'b1;
            end
            default: begin
              // byte moves need a transfer in progress
              if (l_reg.busy) l_next.st = L_BYTE;
              else begin
                l_next.r_nack = 1'b1;
                done          = 1'b1;
              end
            end
          endcase
        end
      end
      L_START: begin
        if (tick) begin
          l_next.qtr = l_reg.qtr + 2'h1;
          case (l_reg.qtr)
            2'h0: l_next.sda_oe = 1'b0;
            2'h1: l_next.scl_oe = 1'b0;
            2'h2: l_next.sda_oe = 1'b1;
            default: begin
              l_next.scl_oe = 1'b1;
              l_next.busy   = 1'b1;
              done          = 1'b1;
            end
          endcase
        end
      end
      L_STOP: begin
        if (tick) begin
          l_next.qtr = l_reg.qtr + 2'h1;
          case (l_reg.qtr)
            2'h0: l_next.sda_oe = 1'b1;
            2'h1: l_next.scl_oe = 1'b0;
            default: begin
              l_next.sda_oe = 1'b0;
              l_next.busy   = 1'b0;
              done          = 1'b1;
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          l_next.qtr = l_reg.qtr + 2'h1;
          case (l_reg.qtr)
            2'h0: begin
              if (l_reg.bit_n < 4'(i2cme_pkg::BYTE_BITS))
                l_next.sda_oe = (l_reg.op == i2cme_pkg::OP_SEND) ? ~l_reg.sh[7] : 1'b0;
              else
                l_next.sda_oe = (l_reg.op == i2cme_pkg::OP_SEND) ? 1'b0 : ~l_reg.rx_nack;
            end
            2'h1: l_next.scl_oe = 1'b0;
            2'h2: begin
              if (l_reg.bit_n < 4'(i2cme_pkg::BYTE_BITS))
                l_next.sh = {l_reg.sh[6:0],
                             (l_reg.op == i2cme_pkg::OP_RECV) ? l_reg.sda_lvl : 1'b0};
              else if (l_reg.op == i2cme_pkg::OP_SEND)
                l_next.r_nack = l_reg.sda_lvl;
            end
            default: begin
              l_next.scl_oe = 1'b1;
              if (l_reg.bit_n == 4'(i2cme_pkg::BYTE_BITS)) begin
                l_next.sda_oe = 1'b1;
                if (l_reg.op == i2cme_pkg::OP_RECV) begin
                  l_next.r_data = l_reg.sh;
                  l_next.r_nack = l_reg.rx_nack;
                end
                done = 1'b1;
              end else begin
                l_next.bit_n = l_reg.bit_n + 4'h1;
              end
            end
          endcase
        end
      end
    endcase
    if (done) begin
      l_next.st      = L_IDLE;
      l_next.ack_tgl = ~l_reg.ack_tgl;
      l_next.r_busy  = l_next.busy;
      l_next.r_idle  = l_reg.scl_lvl & l_reg.sda_lvl;
    end
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      l_reg         <= '0;
      // synchronisers start at the pulled-up idle level, so no false low after reset
      l_reg.sda_s   <= 3'h7;
      l_reg.scl_s   <= 3'h7;
      l_reg.sda_lvl <= 1'b1;
      l_reg.scl_lvl <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  // pads only ever pull low; released lines rise through the pull-ups
  assign scl_out    = l_reg.scl_o;
  assign sda_out    = l_reg.sda_o;
  assign scl_oe_out = l_reg.scl_oe;
  assign sda_oe_out = l_reg.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks, system domain
  sequence s_ee_write_done;
    (s_reg.st == S_WAIT) && ack_new && (s_reg.cmd.op == i2cme_pkg::OP_STOP) && s_reg.ee_data;
  endsequence

  a_cfg_gates_push: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !pins_cfg_in |=> (u_fifo.f_reg.cnt <= $past(u_fifo.f_reg.cnt)))
    else $error("operation queued before pins were configured");

  a_wr_wait_start: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    s_ee_write_done |=> wr_wait_out [*8])
    else $error("eeprom write time not started after stop");

  a_wr_wait_holds: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    wr_wait_out |=> $stable(s_reg.req_tgl))
    else $error("operation dispatched during eeprom write time");

  a_rsp_one_pulse: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rsp_valid_out |=> !rsp_valid_out)
    else $error("answer pulse longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // checks, link domain
  sequence s_go_start;
    (l_reg.st == L_IDLE) && req_new && (s_reg.cmd.op == i2cme_pkg::OP_START);
  endsequence

  sequence s_go_stop;
    (l_reg.st == L_IDLE) && req_new && (s_reg.cmd.op == i2cme_pkg::OP_STOP) && l_reg.busy;
  endsequence

  a_idle_lines_free: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    s_go_start and (!l_reg.busy) |-> !scl_oe_out && !sda_oe_out)
    else $error("lines not released while idle");

  a_restart_edge: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    s_go_start and l_reg.busy |-> ##[1:1000] ($rose(sda_oe_out) && !scl_oe_out))
    else $error("repeated start edge missing");

  a_stop_frees_bus: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    s_go_stop |-> ##[1:1000] (!l_reg.busy && !scl_oe_out && !sda_oe_out))
    else $error("stop did not release the bus");

  a_busy_lines_low: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    (l_reg.st == L_IDLE) && l_reg.busy |-> scl_oe_out && sda_oe_out)
    else $error("lines not held low between operations");

  a_ack_released: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    (l_reg.st == L_BYTE) && (l_reg.bit_n == 4'h8) && (l_reg.qtr != 2'h0)
      && (l_reg.op == i2cme_pkg::OP_SEND) |-> !sda_oe_out)
    else $error("sda driven during acknowledge clock");

  a_pads_open_drain: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
    $rose(scl_oe_out) |-> !scl_out && !sda_out)
    else $error("pad driven high");
endmodule : i2cme_engine

`default_nettype wire

//--- pkg/i2cme_pkg.sv
// i2cme_pkg: shared types and constants of the i2c master byte engine.
// assumes a 10 MHz system clock and a separate free-running link clock.
`default_nettype none

package i2cme_pkg;

  // operations the user queues to the engine
  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_SEND,
    OP_RECV
  } i2cme_op_t;

  // one queued operation; nack is the acknowledge level sent after a received byte
  typedef struct packed {
    i2cme_op_t   op;
    logic [7:0]  data;
    logic        nack;
  } i2cme_cmd_t;

  // answer to one operation
  typedef struct packed {
    logic [7:0]  data;
    logic        nack;
    logic        busy;
    logic        lines_high;
  } i2cme_rsp_t;

  ////////////////////////////////////////////////////////////////////////////
  // clocks and timing
  localparam int SYS_CLK_HZ   = 10_000_000;
  localparam int LINK_CLK_HZ  = 33_333_333;
  localparam int SCL_HZ       = 100_000;
  localparam int QTR_CYC      = (LINK_CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int WR_TIME_MS   = 5;
  localparam int WR_CYC       = WR_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int FIFO_DEPTH   = 4;
  localparam int BYTE_BITS    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // control byte layout of a serial eeprom
  localparam logic [3:0] EE_TYPE      = 4'hA;
  localparam int         CTRL_TYPE_LSB = 4;
  localparam int         CTRL_CS_LSB   = 1;
  localparam int         CTRL_DIR_BIT  = 0;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic       DIR_WRITE     = 1'h0;
  localparam logic [1:0] EE_DATA_IDX   = 2'h3;

endpackage : i2cme_pkg

`default_nettype wire

//--- bench/i2cme_ee_model.sv
// i2cme_ee_model: behavioural serial eeprom slave on the engine's lines.
// assumes the bench resolves both open-drain lines with pull-ups.
`default_nettype none
module i2cme_ee_model #(
  parameter logic [2:0] CHIP = 3'h0
) (
  input  wire logic scl_in,     // resolved scl level
  input  wire logic sda_in,     // resolved sda level
  output logic      sda_oe_out  // high pulls sda low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [256];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        rd;
  logic        sel;
  int          n;
  int          idx;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    sda_oe_out = 1'b0;
    ptr = 16'h0000;
    sel = 1'b0;
    rd = 1'b0;
    n = 0;
    idx = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // start and stop: sda moving while scl is high
  always @(negedge sda_in) if (scl_in) begin
    n = 0;
    idx = 0;
    rd = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) sel = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // bits are taken on scl rising and driven after scl falls
  always @(posedge scl_in) begin
    if (n < 8) sh = {sh[6:0], sda_in};
    else if (rd && sda_in) sel = 1'b0;  // master nack ends the read
    n = (n == 8) ? 0 : n + 1;
  end
  always @(negedge scl_in) begin
    sda_oe_out = 1'b0;
    if (n == 8) begin
      if (rd) ptr = ptr + 16'h0001;  // address advances per byte read
      else begin
        if (idx == 0) begin
          sel = (sh[7:4] == 4'hA) && (sh[3:1] == CHIP);
          rd = sel & sh[0];
        end
        else if (sel && idx == 1) ptr[15:8] = sh;
        else if (sel && idx == 2) ptr[7:0] = sh;
        else if (sel) begin
          mem[ptr[7:0]] = sh;
          ptr = ptr + 16'h0001;
        end
        idx = idx + 1;
        sda_oe_out = sel;  // ack on the ninth clock
      end
    end
    else if (rd && sel) sda_oe_out = ~mem[ptr[7:0]][7-n];
  end
endmodule : i2cme_ee_model
`default_nettype wire

//--- bench/tb_top.sv
// tb_top: self-checking bench of the i2c master byte engine.
// assumes the eeprom model on the far side and pull-ups on both lines.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR = 40;
  logic                  clk = 1'b0;
  logic                  link_clk = 1'b0;
  logic                  rst_n;
  logic                  pins_cfg;
  logic                  cmd_valid;
  i2cme_pkg::i2cme_cmd_t cmd;
  logic                  cmd_ready;
  logic                  rsp_valid;
  i2cme_pkg::i2cme_rsp_t rsp;
  logic                  wr_wait;
  logic                  scl_drv;
  logic                  scl_oe;
  logic                  sda_drv;
  logic                  sda_oe;
  logic                  ee_oe;
  wire                   scl = ~scl_oe;
  wire                   sda = ~(sda_oe | ee_oe);
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  i2cme_pkg::i2cme_rsp_t rq[$];

  i2cme_engine #(.WR_WAIT_CYC(WR), .QTR_CYC(8), .FIFO_DEPTH(4)) uut (
    .clock_in(clk), .reset_n_in(rst_n), .link_clk_in(link_clk), .pins_cfg_in(pins_cfg),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_out(rsp), .wr_wait_out(wr_wait), .scl_in(scl),
    .scl_out(scl_drv), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_out(sda_oe));
  i2cme_ee_model ee (.scl_in(scl), .sda_in(sda), .sda_oe_out(ee_oe));

  initial forever #50 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge clk) if (rsp_valid === 1'b1) rq.push_back(rsp);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("BAD %0t: run hung", $time);
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic put(i2cme_pkg::i2cme_op_t op, logic [7:0] d, logic nk);
    cmd_valid = 1'b1;
    cmd = '{op: op, data: d, nack: nk};
    while (cmd_ready !== 1'b1) tick();
    tick();
  endtask : put
  task automatic get(logic [7:0] d, logic nk, logic bz);
    i2cme_pkg::i2cme_rsp_t r;
    for (int i = 0; i < 3000 && rq.size() == 0; i++) tick();
    r = (rq.size() != 0) ? rq.pop_front() : 'x;
    chk(r.data, d);
    chk(8'(r.nack), 8'(nk));
    chk(8'(r.busy), 8'(bz));
    // levels are taken as the operation ends: both high only on an unanswered
    // ninth clock, a refused move or a stop on the idle bus
    chk(8'(r.lines_high), 8'(nk));
  endtask : get
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    chk({6'h00, scl, sda}, 8'h03);
    chk({6'h00, scl_drv, sda_drv}, 8'h00);
    chk({6'h00, cmd_ready, wr_wait}, 8'h02);
    $display("test idle done");
  endtask : t_idle
  task automatic t_pins();
    pins_cfg = 1'b0;
    cmd_valid = 1'b1;
    cmd = '{op: i2cme_pkg::OP_START, data: 8'h00, nack: 1'b0};
    repeat (60) tick();
    cmd_valid = 1'b0;
    pins_cfg = 1'b1;
    repeat (60) tick();
    chk(8'(rq.size()), 8'h00);
    chk({7'h00, sda}, 8'h01);
    $display("test pins done");
  endtask : t_pins
  task automatic t_write();
    int n = 0;
    put(i2cme_pkg::OP_START, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'hA0, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'h10, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'h3C, 1'b0);
    put(i2cme_pkg::OP_STOP, 8'h00, 1'b0);
    cmd_valid = 1'b0;
    get(8'h00, 1'b0, 1'b1);
    get(8'hA0, 1'b0, 1'b1);
    get(8'h00, 1'b0, 1'b1);
    get(8'h10, 1'b0, 1'b1);
    get(8'h3C, 1'b0, 1'b1);
    get(8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 5 && wr_wait !== 1'b1; i++) tick();
    while (wr_wait === 1'b1 && n < 1000) begin
      n++;
      tick();
    end
    // the answer is queued one cycle into the wait
    chk(8'(n), 8'(WR - 1));
    chk(ee.mem[16], 8'h3C);
    chk({6'h00, scl, sda}, 8'h03);
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    put(i2cme_pkg::OP_START, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'hA0, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'h10, 1'b0);
    put(i2cme_pkg::OP_START, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'hA1, 1'b0);
    put(i2cme_pkg::OP_RECV, 8'hFF, 1'b0);
    put(i2cme_pkg::OP_RECV, 8'hFF, 1'b1);
    put(i2cme_pkg::OP_STOP, 8'h00, 1'b0);
    cmd_valid = 1'b0;
    get(8'h00, 1'b0, 1'b1);
    get(8'hA0, 1'b0, 1'b1);
    get(8'h00, 1'b0, 1'b1);
    get(8'h10, 1'b0, 1'b1);
    get(8'h00, 1'b0, 1'b1);
    get(8'hA1, 1'b0, 1'b1);
    get(8'h3C, 1'b0, 1'b1);
    get(8'h11 ^ 8'h5A, 1'b1, 1'b1);
    get(8'h00, 1'b0, 1'b0);
    $display("test read done");
  endtask : t_read
  task automatic t_bad();
    put(i2cme_pkg::OP_SEND, 8'hA0, 1'b0);
    put(i2cme_pkg::OP_START, 8'h00, 1'b0);
    put(i2cme_pkg::OP_SEND, 8'hA2, 1'b0);
    put(i2cme_pkg::OP_STOP, 8'h00, 1'b0);
    cmd_valid = 1'b0;
    get(8'hA0, 1'b1, 1'b0);
    get(8'h00, 1'b0, 1'b1);
    get(8'hA2, 1'b1, 1'b1);
    get(8'h00, 1'b0, 1'b0);
    $display("test bad address done");
  endtask : t_bad
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    rst_n = 1'b0;
    pins_cfg = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_idle();
    t_pins();
    t_write();
    t_read();
    t_bad();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
